// file: core/irc_cfg.svh
// Constants for the interrupt and reset sequencer
`ifndef IRC_CFG_SVH
`define IRC_CFG_SVH
// ==========================================================
// Vector addresses (first byte of each pair)
`define VEC_RESET 13'h1ffe
`define VEC_TRAP 13'h1ffc
`define VEC_EXT 13'h1ffa
`define VEC_TIMER 13'h1ff8
// ==========================================================
// Timing, in internal clock cycles
`define POR_STAB_TCYC 4064
`define POR_STAB_CYC 12'(`POR_STAB_TCYC)
`define STOP_STAB_CYC 12'(`POR_STAB_TCYC)
// Reset pin low time in tenths of a machine cycle, rounded up
`define RST_PIN_MIN_TENTHS 15
`define RST_PIN_MIN_CYC 2'((`RST_PIN_MIN_TENTHS + 9) / 10)
`define LATCH_CLR_CYC 4'd9
// ==========================================================
// Register offsets and fields
`define REG_CTRL 8'h00
`define REG_STAT 8'h01
`define CTRL_TMR_EN_RST 3'h0
`define STAT_EXT_BIT 0
`define STAT_TMR_BIT 1
`define STAT_LINE_BIT 2
`define STAT_LATCH_BIT 3
`endif

// file: core/irc_pkg.sv
// Types shared by the interrupt and reset sequencer
package irc_pkg;
  typedef enum logic [1:0] {ST_RUN, ST_WAIT, ST_STOP, ST_STAB} pm_state_t;
  typedef enum logic [2:0] {VS_NONE, VS_RESET, VS_TRAP, VS_EXT, VS_TIMER} vec_sel_t;
endpackage : irc_pkg

// file: core/ext_request_latch.sv
// External request pin and port A request combining and latch
`timescale 1ns/1ps
module ext_request_latch import irc_pkg::*; (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic irq_pin_n,
  input wire logic [7:0] port_a_request_pins,
  input wire logic [7:0] pa_irq_option,
  input wire logic [7:0] pa_dir_out,
  input wire logic edge_only_opt,
  input wire logic latch_clear,
  output logic ext_req,
  output logic request_line,
  output logic latch_q
);
  // ==========================================================
  // Pin synchronisers
  logic [8:0] raw;
  logic [8:0] sync1;
  logic [8:0] sync2;
  logic [7:0] pa_src_en;
  logic line_n;
  logic line_prev;

  assign raw = {irq_pin_n, port_a_request_pins};

  for (genvar i = 0; i < 9; i++) begin : g_sync
    always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
        sync1[i] <= 1'b1;
        sync2[i] <= 1'b1;
      end else begin
        sync1[i] <= raw[i];
        sync2[i] <= sync1[i];
      end
    end
  end

  // ==========================================================
  // Combined line, edge latch
  // Output pins drop out even with the option chosen
  assign pa_src_en = pa_irq_option & ~pa_dir_out;
  assign line_n = sync2[8] & (&(sync2[7:0] | ~pa_src_en));

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      line_prev <= 1'b1;
    end else begin
      line_prev <= line_n;
    end
  end

  // Set wins over clear so an edge in the clear cycle survives
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      latch_q <= 1'b0;
    end else if (line_prev && !line_n) begin
      latch_q <= 1'b1;
    end else if (latch_clear) begin
      latch_q <= 1'b0;
    end
  end

  assign ext_req = latch_q | (~edge_only_opt & ~line_n);
  assign request_line = line_n;

  a_edge_only_level: assert property (@(posedge sys_clk) disable iff (sys_rst)
    edge_only_opt && !latch_q |-> !ext_req)
    else $error("level request seen in edge-only option");
endmodule : ext_request_latch

// file: core/reset_sequencer.sv
// Reset source combining, power-on delay and restart pulse
`timescale 1ns/1ps
`include "irc_cfg.svh"
module reset_sequencer import irc_pkg::*; (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic reset_pin_n,
  input wire logic wdog_timeout,
  input wire logic wdog_enable_opt,
  input wire logic [1:0] op_mode_strap,
  output logic cpu_reset,
  output logic reset_start,
  output logic [1:0] op_mode
);
  logic pin_s1;
  logic pin_s2;
  logic [1:0] low_cnt;
  logic [11:0] por_cnt;
  logic pin_hold;
  logic wd_hit;
  logic wd_cause;
  logic next_reset;

  // ==========================================================
  // Pin synchroniser and low-time qualifier
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pin_s1 <= 1'b1;
      pin_s2 <= 1'b1;
    end else begin
      pin_s1 <= reset_pin_n;
      pin_s2 <= pin_s1;
    end
  end

  // Glitches shorter than the minimum low time are not a reset
  always_ff @(posedge sys_clk) begin
    if (sys_rst || pin_s2) begin
      low_cnt <= 2'h0;
    end else if (low_cnt != `RST_PIN_MIN_CYC) begin
      low_cnt <= low_cnt + 2'h1;
    end
  end
  assign pin_hold = (low_cnt == `RST_PIN_MIN_CYC);

  // ==========================================================
  // Power-on stabilisation
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      por_cnt <= `POR_STAB_CYC;
    end else if (por_cnt != 12'h0) begin
      por_cnt <= por_cnt - 12'h1;
    end
  end

  assign wd_hit = wdog_timeout & wdog_enable_opt;
  assign next_reset = (por_cnt != 12'h0) || pin_hold || wd_hit;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cpu_reset <= 1'b1;
      reset_start <= 1'b0;
    end else begin
      cpu_reset <= next_reset;
      reset_start <= cpu_reset && !next_reset;
    end
  end

  // Watchdog restarts keep the mode caught at the last full reset
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wd_cause <= 1'b0;
      op_mode <= 2'h0;
    end else begin
      if (next_reset) begin
        wd_cause <= wd_hit && (por_cnt == 12'h0) && !pin_hold;
      end
      if (cpu_reset && !next_reset && !wd_cause) begin
        op_mode <= op_mode_strap;
      end
    end
  end

  a_pin_holds_reset: assert property (@(posedge sys_clk) disable iff (sys_rst)
    pin_hold |=> cpu_reset)
    else $error("reset released while pin still low");
endmodule : reset_sequencer

// file: core/mcu_interrupt_reset_control.sv
// Interrupt arbitration, vectoring, low-power wake and reset control
//
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "irc_cfg.svh"
module mcu_interrupt_reset_control import irc_pkg::*; (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic irq_pin_n,
  input wire logic [7:0] port_a_request_pins,
  input wire logic [7:0] pa_irq_option,
  input wire logic [7:0] pa_dir_out,
  input wire logic edge_only_opt,
  input wire logic capture_event_flag,
  input wire logic compare_match_flag,
  input wire logic counter_wrap_flag,
  input wire logic reset_pin_n,
  input wire logic wdog_timeout,
  input wire logic wdog_enable_opt,
  input wire logic [1:0] op_mode_strap,
  input wire logic stop_to_halt_opt,
  input wire logic instr_end,
  input wire logic cur_is_trap,
  input wire logic trap_fetch,
  input wire logic i_mask,
  input wire logic stop_exec,
  input wire logic wait_exec,
  input wire logic vector_read,
  output logic cpu_reset,
  output logic [1:0] op_mode,
  output logic vector_load,
  output logic [12:0] vector_addr,
  output logic push_regs,
  output logic mask_set,
  output logic fetch_next,
  output logic request_line,
  output logic osc_run,
  output logic cpu_clk_run,
  output logic timer_clk_run
);
  // ==========================================================
  // Declarations
  pm_state_t state;
  pm_state_t next_state;
  vec_sel_t next_sel;
  vec_sel_t cur_sel;
  logic [2:0] tmr_en;
  logic [2:0] tmr_flags;
  logic timer_req;
  logic ext_req;
  logic latch_q;
  logic latch_clear;
  logic [3:0] clr_cnt;
  logic [11:0] stab_cnt;
  logic reset_start;
  logic snap_ext;
  logic snap_tmr;
  logic boundary;

  // ==========================================================
  // Request sources
  ext_request_latch u_ext (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .irq_pin_n(irq_pin_n),
    .port_a_request_pins(port_a_request_pins),
    .pa_irq_option(pa_irq_option),
    .pa_dir_out(pa_dir_out),
    .edge_only_opt(edge_only_opt),
    .latch_clear(latch_clear | cpu_reset),
    .ext_req(ext_req),
    .request_line(request_line),
    .latch_q(latch_q)
  );

  reset_sequencer u_rst (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .reset_pin_n(reset_pin_n),
    .wdog_timeout(wdog_timeout),
    .wdog_enable_opt(wdog_enable_opt),
    .op_mode_strap(op_mode_strap),
    .cpu_reset(cpu_reset),
    .reset_start(reset_start),
    .op_mode(op_mode)
  );

  assign tmr_flags = {capture_event_flag, compare_match_flag, counter_wrap_flag};
  assign timer_req = |(tmr_flags & tmr_en);
  assign boundary = instr_end && (state == ST_RUN) && !cpu_reset;

  // ==========================================================
  // Register port
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tmr_en <= `CTRL_TMR_EN_RST;
    end else if (reg_wr && reg_addr == `REG_CTRL) begin
      tmr_en <= reg_wdata[2:0];
    end
  end

  // Unmapped offsets and idle cycles read zero
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd && reg_addr == `REG_CTRL) begin
      reg_rdata <= {5'h00, tmr_en};
    end else if (reg_rd && reg_addr == `REG_STAT) begin
      reg_rdata <= 8'h00;
      reg_rdata[`STAT_EXT_BIT] <= ext_req;
      reg_rdata[`STAT_TMR_BIT] <= timer_req;
      reg_rdata[`STAT_LINE_BIT] <= request_line;
      reg_rdata[`STAT_LATCH_BIT] <= latch_q;
      reg_rdata[5:4] <= 2'(state);
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ==========================================================
  // Trap ordering snapshot
  // Requests raised after the trap fetch must wait behind it
  always_ff @(posedge sys_clk) begin
    if (sys_rst || cpu_reset) begin
      snap_ext <= 1'b0;
      snap_tmr <= 1'b0;
    end else if (trap_fetch) begin
      snap_ext <= ext_req;
      snap_tmr <= timer_req;
    end else if (boundary && cur_is_trap) begin
      snap_ext <= 1'b0;
      snap_tmr <= 1'b0;
    end
  end

  // ==========================================================
  // Boundary arbitration
  always_comb begin
    next_sel = VS_NONE;
    if (boundary) begin
      if (cur_is_trap) begin
        if (!i_mask && snap_ext && ext_req) begin
          next_sel = VS_EXT;
        end else if (!i_mask && snap_tmr && timer_req) begin
          next_sel = VS_TIMER;
        end else begin
          next_sel = VS_TRAP;
        end
      end else if (!i_mask && ext_req) begin
        next_sel = VS_EXT;
      end else if (!i_mask && timer_req) begin
        next_sel = VS_TIMER;
      end
    end
  end

  // ==========================================================
  // Vector and entry outputs
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      vector_load <= 1'b0;
      push_regs <= 1'b0;
      mask_set <= 1'b0;
      fetch_next <= 1'b0;
      vector_addr <= `VEC_RESET;
      cur_sel <= VS_NONE;
    end else begin
      vector_load <= 1'b0;
      push_regs <= 1'b0;
      mask_set <= 1'b0;
      fetch_next <= 1'b0;
      if (reset_start) begin
        vector_load <= 1'b1;
        mask_set <= 1'b1;
        vector_addr <= `VEC_RESET;
        cur_sel <= VS_RESET;
      end else if (boundary) begin
        case (next_sel)
          VS_TRAP: begin
            vector_addr <= `VEC_TRAP;
          end
          VS_EXT: begin
            vector_addr <= `VEC_EXT;
          end
          VS_TIMER: begin
            vector_addr <= `VEC_TIMER;
          end
          default: begin
            vector_addr <= vector_addr;
          end
        endcase
        if (next_sel == VS_NONE) begin
          fetch_next <= 1'b1;
        end else begin
          vector_load <= 1'b1;
          push_regs <= 1'b1;
          mask_set <= 1'b1;
          cur_sel <= next_sel;
        end
      end
    end
  end

  // ==========================================================
  // External latch clear timer
  always_ff @(posedge sys_clk) begin
    if (sys_rst || cpu_reset) begin
      clr_cnt <= 4'h0;
    end else if (vector_read && cur_sel == VS_EXT) begin
      clr_cnt <= `LATCH_CLR_CYC;
    end else if (clr_cnt != 4'h0) begin
      clr_cnt <= clr_cnt - 4'h1;
    end
  end
  // Level sources stay asserted past this clear and re-enter
  assign latch_clear = (clr_cnt == 4'h1);

  // ==========================================================
  // Low-power modes
  always_comb begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (!cpu_reset && stop_exec) begin
          next_state = stop_to_halt_opt ? ST_WAIT : ST_STOP;
        end else if (!cpu_reset && wait_exec) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (cpu_reset || ext_req || timer_req) begin
          next_state = ST_RUN;
        end
      end
      ST_STOP: begin
        if (cpu_reset) begin
          next_state = ST_RUN;
        end else if (ext_req) begin
          next_state = ST_STAB;
        end
      end
      ST_STAB: begin
        if (cpu_reset || stab_cnt == 12'h1) begin
          next_state = ST_RUN;
        end
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state <= ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // Oscillator restart needs the full stabilisation delay
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      stab_cnt <= 12'h0;
    end else if (state == ST_STOP && next_state == ST_STAB) begin
      stab_cnt <= `STOP_STAB_CYC;
    end else if (stab_cnt != 12'h0) begin
      stab_cnt <= stab_cnt - 12'h1;
    end
  end

  assign osc_run = (state != ST_STOP);
  assign timer_clk_run = (state == ST_RUN) || (state == ST_WAIT);
  assign cpu_clk_run = (state == ST_RUN);

  // ==========================================================
  // Checks
  a_reset_vector: assert property (@(posedge sys_clk) disable iff (sys_rst)
    reset_start |=> vector_load && mask_set && vector_addr == `VEC_RESET)
    else $error("reset did not load reset vector with mask");

  a_ext_over_timer: assert property (@(posedge sys_clk) disable iff (sys_rst)
    boundary && !cur_is_trap && !i_mask && ext_req && timer_req
    |=> push_regs && vector_addr == `VEC_EXT)
    else $error("timer served ahead of external request");

  a_masked_boundary: assert property (@(posedge sys_clk) disable iff (sys_rst)
    boundary && !cur_is_trap && i_mask |=> fetch_next && !push_regs)
    else $error("interrupt entered while masked");

  a_trap_unmasked: assert property (@(posedge sys_clk) disable iff (sys_rst)
    boundary && cur_is_trap && i_mask |=> push_regs && vector_addr == `VEC_TRAP)
    else $error("software trap not taken under mask");

  a_timer_vector: assert property (@(posedge sys_clk) disable iff (sys_rst)
    boundary && !cur_is_trap && !i_mask && !ext_req && timer_req
    |=> push_regs && mask_set && vector_addr == `VEC_TIMER)
    else $error("timer request not vectored");

  a_latch_clear_time: assert property (@(posedge sys_clk) disable iff (sys_rst || cpu_reset)
    vector_read && cur_sel == VS_EXT ##1 !vector_read [*8] |=> latch_clear)
    else $error("external latch not cleared nine cycles after read");

  a_stop_sleeps: assert property (@(posedge sys_clk) disable iff (sys_rst)
    state == ST_STOP && !ext_req && !cpu_reset |=> state == ST_STOP && !osc_run)
    else $error("stop left without request or reset");

  a_wait_timer_wake: assert property (@(posedge sys_clk) disable iff (sys_rst)
    state == ST_WAIT && timer_req |=> cpu_clk_run && timer_clk_run)
    else $error("wait not ended by timer request");

  a_trap_after_pending: assert property (@(posedge sys_clk) disable iff (sys_rst)
    boundary && cur_is_trap && !i_mask && !snap_ext && !snap_tmr
    |=> vector_addr == `VEC_TRAP)
    else $error("later request overtook software trap");
endmodule : mcu_interrupt_reset_control

// file: tb/cpu_core_model.sv
// Behavioural CPU core facing the sequencer: mask bit and vector fetch
`timescale 1ns/1ps
module cpu_core_model (
  input wire logic sys_clk,
  input wire logic cpu_reset,
  input wire logic vector_load,
  input wire logic mask_set,
  input wire logic handler_ret,
  input wire logic [3:0] read_delay,
  output logic i_mask,
  output logic vector_read
);
  logic [3:0] vr_cnt;
  // ==========================================================
  // Global mask bit, set by reset and entry, cleared by return
  always_ff @(posedge sys_clk) begin
    if (cpu_reset || mask_set) begin
      i_mask <= 1'b1;
    end else if (handler_ret) begin
      i_mask <= 1'b0;
    end
  end
  // ==========================================================
  // First vector byte read a chosen time after the load
  always_ff @(posedge sys_clk) begin
    vector_read <= (vr_cnt == 4'h1);
    if (cpu_reset) begin
      vr_cnt <= 4'h0;
    end else if (vector_load) begin
      vr_cnt <= read_delay;
    end else if (vr_cnt != 4'h0) begin
      vr_cnt <= vr_cnt - 4'h1;
    end
  end
endmodule : cpu_core_model

// file: tb/test_mcu_interrupt_reset_control.sv
// Self-checking bench for the interrupt and reset sequencer
`timescale 1ns/1ps
`include "irc_cfg.svh"
`define CHK(a, e) check_val(32'(a), 32'(e))
module test_mcu_interrupt_reset_control;
  localparam int RET = 0, FETCH = 1, STOP = 2, WAITI = 3, WDOG = 4;
  logic sys_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d;
  logic [7:0] port_a_request_pins = 8'hff, pa_irq_option = 8'h00, pa_dir_out = 8'h00;
  logic irq_pin_n = 1'b1, edge_only_opt = 1'b1, reset_pin_n = 1'b1;
  logic capture_event_flag = 1'b0, compare_match_flag = 1'b0, counter_wrap_flag = 1'b0;
  logic wdog_timeout = 1'b0, wdog_enable_opt = 1'b0, stop_to_halt_opt = 1'b0;
  logic [1:0] op_mode_strap = 2'h1, op_mode;
  logic instr_end = 1'b0, cur_is_trap = 1'b0, trap_fetch = 1'b0, stop_exec = 1'b0;
  logic wait_exec = 1'b0, handler_ret = 1'b0, i_mask, vector_read, cpu_reset;
  logic vector_load, push_regs, mask_set, fetch_next, request_line;
  logic osc_run, cpu_clk_run, timer_clk_run;
  logic [12:0] vector_addr;
  logic [3:0] rd_dly = 4'h2;
  int fail_count = 0, samples_checked = 0, cycles = 0, n;

  always #5 sys_clk = ~sys_clk;

  mcu_interrupt_reset_control mcu_interrupt_reset_control_inst (.sys_clk, .sys_rst,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq_pin_n, .port_a_request_pins,
    .pa_irq_option, .pa_dir_out, .edge_only_opt, .capture_event_flag, .compare_match_flag,
    .counter_wrap_flag, .reset_pin_n, .wdog_timeout, .wdog_enable_opt, .op_mode_strap,
    .stop_to_halt_opt, .instr_end, .cur_is_trap, .trap_fetch, .i_mask, .stop_exec,
    .wait_exec, .vector_read, .cpu_reset, .op_mode, .vector_load, .vector_addr,
    .push_regs, .mask_set, .fetch_next, .request_line, .osc_run, .cpu_clk_run,
    .timer_clk_run);
  cpu_core_model cpu_core_model_inst (.sys_clk, .cpu_reset, .vector_load, .mask_set,
    .handler_ret, .read_delay(rd_dly), .i_mask, .vector_read);

  // ==========================================================
  // Shared tasks
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict
  task automatic check_val(input logic [31:0] act, input logic [31:0] exp);
    samples_checked++;
    if (act !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, act, exp);
    end
  endtask : check_val
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic reg_write(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [7:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : reg_read
  task automatic pulse(input int w);
    @(posedge sys_clk);
    case (w)
      RET: handler_ret <= 1'b1;
      FETCH: trap_fetch <= 1'b1;
      STOP: stop_exec <= 1'b1;
      WAITI: wait_exec <= 1'b1;
      default: wdog_timeout <= 1'b1;
    endcase
    @(posedge sys_clk);
    {handler_ret, trap_fetch, stop_exec, wait_exec, wdog_timeout} <= 5'h00;
    #1;
  endtask : pulse
  // One instruction end; exp high means entry at addr, low means plain fetch
  task automatic boundary(input logic trap, input logic exp, input logic [12:0] addr);
    @(posedge sys_clk);
    instr_end <= 1'b1;
    cur_is_trap <= trap;
    @(posedge sys_clk);
    instr_end <= 1'b0;
    cur_is_trap <= 1'b0;
    #1 `CHK({vector_load, push_regs, mask_set, fetch_next}, {exp, exp, exp, !exp});
    if (exp) `CHK(vector_addr, addr);
  endtask : boundary
  task automatic wait_vr();
    int k;
    for (k = 0; vector_read !== 1'b1 && k < 20; k++) tick(1);
    `CHK(k < 20, 1'b1);
  endtask : wait_vr
  // Handler body: wait out the latch clear, then return
  task automatic service();
    wait_vr();
    tick(12);
    pulse(RET);
  endtask : service
  task automatic reset_done(output int k);
    for (k = 0; cpu_reset !== 1'b0 && k < 9000; k++) tick(1);
    `CHK(vector_load, 1'b0);
    tick(1);
    `CHK({vector_load, mask_set, vector_addr}, {2'b11, `VEC_RESET});
  endtask : reset_done

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 45000) begin
      fail_count++;
      print_verdict();
    end
  end

  // ==========================================================
  // Test sequence
  initial begin
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    tick(1);
    `CHK({cpu_reset, request_line}, 2'b11);
    reset_done(n);
    `CHK(n inside {[4060:4068]}, 1'b1);
    reg_read(`REG_CTRL, d);
    `CHK(d[2:0], 3'h0);
    reg_write(`REG_CTRL, 8'h07);
    reg_read(`REG_CTRL, d);
    `CHK(d[2:0], 3'h7);
    reg_read(8'h05, d);
    `CHK(d, 8'h00);
    pulse(RET);
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk);
      {capture_event_flag, compare_match_flag, counter_wrap_flag} <= 3'h4 >> i;
      boundary(1'b0, 1'b1, `VEC_TIMER);
      if (i < 2) pulse(RET);
    end
    boundary(1'b0, 1'b0, 13'h0000);
    pulse(RET);
    reg_write(`REG_CTRL, 8'h04);
    boundary(1'b0, 1'b0, 13'h0000);
    reg_write(`REG_CTRL, 8'h07);
    // External and timer together
    @(posedge sys_clk);
    counter_wrap_flag <= 1'b0;
    capture_event_flag <= 1'b1;
    irq_pin_n <= 1'b0;
    tick(6);
    boundary(1'b0, 1'b1, `VEC_EXT);
    wait_vr();
    tick(8);
    reg_read(`REG_STAT, d);
    `CHK(d[3], 1'b1);
    reg_read(`REG_STAT, d);
    `CHK(d[3], 1'b0);
    pulse(RET);
    boundary(1'b0, 1'b1, `VEC_TIMER);
    @(posedge sys_clk);
    capture_event_flag <= 1'b0;
    pulse(RET);
    // Pin still low: edge-only ignores it, edge-and-level enters
    boundary(1'b0, 1'b0, 13'h0000);
    @(posedge sys_clk);
    edge_only_opt <= 1'b0;
    boundary(1'b0, 1'b1, `VEC_EXT);
    @(posedge sys_clk);
    irq_pin_n <= 1'b1;
    service();
    boundary(1'b0, 1'b0, 13'h0000);
    // Port A sources, with a slow vector fetch
    @(posedge sys_clk);
    edge_only_opt <= 1'b1;
    rd_dly <= 4'h6;
    pa_irq_option <= 8'h01;
    port_a_request_pins <= 8'hfe;
    tick(4);
    `CHK(request_line, 1'b0);
    boundary(1'b0, 1'b1, `VEC_EXT);
    service();
    @(posedge sys_clk);
    port_a_request_pins <= 8'hfd;
    tick(4);
    `CHK(request_line, 1'b1);
    reg_read(`REG_STAT, d);
    `CHK(d[3:0], 4'h4);
    @(posedge sys_clk);
    pa_dir_out <= 8'h01;
    port_a_request_pins <= 8'hfe;
    tick(4);
    `CHK(request_line, 1'b1);
    boundary(1'b0, 1'b0, 13'h0000);
    @(posedge sys_clk);
    port_a_request_pins <= 8'hff;
    rd_dly <= 4'h2;
    // Pin must be synced high before it rejoins, or a false edge latches
    repeat (4) @(posedge sys_clk);
    pa_dir_out <= 8'h00;
    // Software trap: mask ignored, ordering against other requests
    boundary(1'b1, 1'b1, `VEC_TRAP);
    boundary(1'b1, 1'b1, `VEC_TRAP);
    pulse(RET);
    @(posedge sys_clk);
    counter_wrap_flag <= 1'b1;
    pulse(FETCH);
    boundary(1'b1, 1'b1, `VEC_TIMER);
    @(posedge sys_clk);
    counter_wrap_flag <= 1'b0;
    pulse(RET);
    boundary(1'b1, 1'b1, `VEC_TRAP);
    pulse(RET);
    pulse(FETCH);
    @(posedge sys_clk);
    counter_wrap_flag <= 1'b1;
    boundary(1'b1, 1'b1, `VEC_TRAP);
    pulse(RET);
    boundary(1'b0, 1'b1, `VEC_TIMER);
    @(posedge sys_clk);
    counter_wrap_flag <= 1'b0;
    pulse(RET);
    // Wait, halt and stop
    pulse(WAITI);
    `CHK({osc_run, cpu_clk_run, timer_clk_run}, 3'b101);
    @(posedge sys_clk);
    compare_match_flag <= 1'b1;
    tick(3);
    `CHK(cpu_clk_run, 1'b1);
    boundary(1'b0, 1'b1, `VEC_TIMER);
    @(posedge sys_clk);
    compare_match_flag <= 1'b0;
    stop_to_halt_opt <= 1'b1;
    pulse(RET);
    pulse(STOP);
    reg_read(`REG_STAT, d);
    `CHK({d[5:4], osc_run, cpu_clk_run}, 4'h6);
    @(posedge sys_clk);
    irq_pin_n <= 1'b0;
    tick(6);
    `CHK(cpu_clk_run, 1'b1);
    boundary(1'b0, 1'b1, `VEC_EXT);
    @(posedge sys_clk);
    irq_pin_n <= 1'b1;
    stop_to_halt_opt <= 1'b0;
    service();
    pulse(STOP);
    `CHK({osc_run, cpu_clk_run}, 2'b00);
    @(posedge sys_clk);
    counter_wrap_flag <= 1'b1;
    tick(8);
    `CHK({osc_run, cpu_clk_run}, 2'b00);
    @(posedge sys_clk);
    counter_wrap_flag <= 1'b0;
    irq_pin_n <= 1'b0;
    for (n = 0; cpu_clk_run !== 1'b1 && n < 6000; n++) tick(1);
    `CHK(n >= 4064 && n < 4080, 1'b1);
    @(posedge sys_clk);
    irq_pin_n <= 1'b1;
    boundary(1'b0, 1'b1, `VEC_EXT);
    service();
    // Watchdog, pin and a second power-on reset
    @(posedge sys_clk);
    op_mode_strap <= 2'h2;
    pulse(WDOG);
    tick(6);
    `CHK(cpu_reset, 1'b0);
    @(posedge sys_clk);
    wdog_enable_opt <= 1'b1;
    // Watchdog reset lasts one cycle; it stands right after the pulse
    pulse(WDOG);
    `CHK(cpu_reset, 1'b1);
    reset_done(n);
    `CHK(op_mode, 2'h1);
    @(posedge sys_clk);
    reset_pin_n <= 1'b0;
    tick(6);
    `CHK(cpu_reset, 1'b1);
    @(posedge sys_clk);
    reset_pin_n <= 1'b1;
    reset_done(n);
    `CHK(op_mode, 2'h2);
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    reset_pin_n <= 1'b0;
    tick(16);
    @(posedge sys_clk);
    sys_rst <= 1'b0;
    tick(4100);
    `CHK(cpu_reset, 1'b1);
    @(posedge sys_clk);
    reset_pin_n <= 1'b1;
    reset_done(n);
    `CHK(n < 8, 1'b1);
    print_verdict();
  end
endmodule : test_mcu_interrupt_reset_control
